// File: src/qgi_pkg.sv
package qgi_pkg;

    // Bus geometry
    localparam int unsigned QGI_AW = 8;                  // APB byte address width
    localparam int unsigned QGI_DW = 32;                 // APB data width

    // Register indices; byte address is four times the index
    localparam logic [5:0] QGI_IDX_GAIN   = 6'h0b;       // Second channel full-scale gain
    localparam logic [5:0] QGI_IDX_ILV    = 6'h0d;       // Interleave control
    localparam logic [5:0] QGI_IDX_STATUS = 6'h10;       // Alignment and sanity status

    // Reset images of the write-only registers
    localparam logic [15:0] QGI_GAIN_RST = 16'h807f;     // Midpoint gain, filler ones
    localparam logic [15:0] QGI_ILV_RST  = 16'h3fff;     // Both mode bits clear

    // Field positions
    localparam int unsigned QGI_GAIN_MSB = 15;           // Gain code top bit
    localparam int unsigned QGI_GAIN_LSB = 7;            // Gain code bottom bit
    localparam int unsigned QGI_ILV_BIT  = 15;           // interleave_enable
    localparam int unsigned QGI_ACP_BIT  = 14;           // auto_phase_control
    localparam int unsigned QGI_ST_LOCK  = 0;            // Phase loop settled
    localparam int unsigned QGI_ST_BAND  = 1;            // Gain outside advised band
    localparam int unsigned QGI_ST_MANIL = 2;            // Interleaving on manual delays

    // Advised gain band and full-scale mapping
    localparam logic [8:0]  QGI_GAIN_LO    = 9'h0c0;     // Lower edge of advised band
    localparam logic [8:0]  QGI_GAIN_HI    = 9'h1c0;     // Upper edge of advised band
    localparam logic [9:0]  QGI_FSR_MIN_MV = 10'h230;    // Full scale at code zero
    localparam logic [17:0] QGI_FSR_SLOPE  = 18'h119;    // Span scaled by 512

    // Timing at the 25 ns bus clock
    localparam int unsigned QGI_CLK_PS        = 25000;   // Clock period in ps
    localparam int unsigned QGI_PD_UPDATE_NS  = 1000;    // Least phase loop update interval
    localparam int unsigned QGI_PD_UPDATE_CYC =
        (QGI_PD_UPDATE_NS * 1000 + QGI_CLK_PS - 1) / QGI_CLK_PS;
    localparam int unsigned QGI_HALF_PER_CYC  = 2;       // Cycles per sample clock half period

    // Mode bits as one carrier
    typedef struct packed {
        logic interleave_enable;                         // Dual edge sampling on
        logic auto_phase_control;                        // Phase loop owns the delay
    } qgi_mode_t;

    // Sampling strobes as one carrier
    typedef struct packed {
        logic i_sample;                                  // First converter samples
        logic q_sample;                                  // Second converter samples
        logic q_from_i_input;                            // Second converter reads shared input
    } qgi_sample_t;

    // Word address hit test, shared by every register decode in qgi_ctrl
    function automatic logic qgi_hit(input logic [QGI_AW-1:0] addr, input logic [5:0] idx);
        return addr[QGI_AW-1:2] == idx && addr[1:0] == 2'h0;
    endfunction

endpackage

// File: src/qgi_phase_align.sv
`timescale 1ns/1ps
module qgi_phase_align
    import qgi_pkg::*;
#(
    parameter int unsigned CW = 3,                           // Coarse field width
    parameter int unsigned FW = 9                            // Fine field width
)(
    input  wire logic               pclk,                    // Bus clock
    input  wire logic               presetn,                 // Async reset, low
    input  wire logic               update,                  // Loop update enable pulse
    input  wire logic               auto_en,                 // Phase loop owns the delay
    input  wire logic [CW-1:0]      manual_coarse,           // Programmed coarse delay
    input  wire logic [FW-1:0]      manual_fine,             // Programmed fine delay
    input  wire logic               phase_early_pin,         // Detector: second edge early
    input  wire logic               phase_late_pin,          // Detector: second edge late
    output logic [CW+FW-1:0]        sample_delay,            // Delay applied between channels
    output logic                    phase_locked             // Loop on and detector sees half period
);
    localparam int unsigned W = CW + FW;

    // Detector pins cross in through two flops each
    logic [1:0] early_s_q;                                   // Early synchroniser
    logic [1:0] late_s_q;                                    // Late synchroniser
    logic [W-1:0] auto_q;                                    // Loop-held delay
    logic [W-1:0] delay_q;                                   // Registered delay out
    logic         lock_q;                                    // Registered lock flag

    // Loop steers toward no early/late reading
    wire step_up   = update && auto_en && late_s_q[1] && !early_s_q[1];
    wire step_down = update && auto_en && early_s_q[1] && !late_s_q[1];
    wire at_top    = &auto_q;
    wire at_bottom = ~|auto_q;
    // Manual fields are ignored entirely while the loop runs
    wire [W-1:0] delay_d = auto_en ? auto_q : {manual_coarse, manual_fine};

    // Synchronisers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            early_s_q <= 2'h0;
            late_s_q  <= 2'h0;
        end
        else
        begin
            early_s_q <= {early_s_q[0], phase_early_pin};
            late_s_q  <= {late_s_q[0], phase_late_pin};
        end
    end

    // Loop integrator; saturates rather than wrapping round a full period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            auto_q <= '0;
        else if (step_up && !at_top)
            auto_q <= auto_q + W'(1);
        else if (step_down && !at_bottom)
            auto_q <= auto_q - W'(1);
    end

    // Output registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            delay_q <= '0;
            lock_q  <= 1'b0;
        end
        else
        begin
            delay_q <= delay_d;
            lock_q  <= auto_en && !early_s_q[1] && !late_s_q[1];
        end
    end

    assign sample_delay = delay_q;
    assign phase_locked = lock_q;

endmodule // qgi_phase_align

// File: src/qgi_ctrl.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps
// Behaviour
// - Full scale tracks nine-bit gain code linearly.
// - Gain code resets to midpoint, no adjustment.
// - Gain changes apply without recalibration.
// - Interleave bit shares one input; resets zero.
// - Interleaved pair samples alternate phases, doubled.
// - Interleave off gives two independent channels.
// - Auto phase bit overrides manual delays; resets zero.
// - Phase loop holds edges half period apart.
// - Auto phase off uses manual delays only.
module qgi_ctrl
    import qgi_pkg::*;
#(
    parameter int unsigned CW        = 3,                    // Coarse delay width
    parameter int unsigned FW        = 9,                    // Fine delay width
    parameter int unsigned HALF_CYC  = QGI_HALF_PER_CYC,     // Sample clock half period
    parameter int unsigned UPD_CYC   = QGI_PD_UPDATE_CYC     // Phase loop update interval
)(
    input  wire logic               pclk,                    // Bus clock, 40 MHz
    input  wire logic               presetn,                 // Async reset, low
    input  wire logic               psel,                    // APB select
    input  wire logic               penable,                 // APB access phase
    input  wire logic               pwrite,                  // APB direction
    input  wire logic [QGI_AW-1:0]  paddr,                   // APB byte address
    input  wire logic [QGI_DW-1:0]  pwdata,                  // APB write data
    output logic [QGI_DW-1:0]       prdata,                  // APB read data
    output logic                    pready,                  // APB ready
    output logic                    pslverr,                 // APB error
    input  wire logic [CW-1:0]      manual_coarse,           // Manual coarse delay
    input  wire logic [FW-1:0]      manual_fine,             // Manual fine delay
    input  wire logic               phase_early_pin,         // Detector early pin
    input  wire logic               phase_late_pin,          // Detector late pin
    output logic [8:0]              q_gain_code,             // Second channel gain code
    output logic [9:0]              q_fullscale_mv,          // Resulting full scale, mV p-p
    output logic                    gain_update,             // Pulse after each gain write
    output qgi_mode_t               mode,                    // Current mode bits
    output qgi_sample_t             sample,                  // Sampling strobes
    output logic [CW+FW-1:0]        sample_delay,            // Inter-channel delay
    output logic                    phase_locked             // Phase loop settled
);
    import qgi_pkg::*;

    // Cycle counter widths
    localparam int unsigned HW = $clog2(HALF_CYC + 1);
    localparam int unsigned UW = $clog2(UPD_CYC + 1);

    // Full scale in mV: 560 at code zero, 700 at midpoint, 840 at top
    function automatic logic [9:0] fsr_mv(input logic [8:0] code);
        logic [17:0] prod;
        prod = 18'(code) * QGI_FSR_SLOPE;
        return QGI_FSR_MIN_MV + 10'(prod[17:9]);
    endfunction

    // Full scale at the reset code, folded to a constant so the reset branch loads a plain value
    localparam logic [9:0] FSR_RST_MV = fsr_mv(QGI_GAIN_RST[QGI_GAIN_MSB:QGI_GAIN_LSB]);

    // Stored control state
    logic [8:0]   gain_q;                                    // Gain code field
    logic         upd_q;                                     // Gain write pulse
    qgi_mode_t    mode_q;                                    // Mode bits
    logic [9:0]   fsr_q;                                     // Registered full scale
    logic [QGI_DW-1:0] rdata_q;                              // Read data, loaded in setup

    // Sampling clock state
    logic [HW-1:0] half_cnt_q;                               // Half period counter
    logic          phase_q;                                  // Low half or high half
    qgi_sample_t   smp_q;                                    // Registered strobes
    logic [UW-1:0] upd_cnt_q;                                // Loop update divider
    logic          upd_tick_q;                               // Loop update pulse

    // Address decode
    wire hit_gain   = qgi_hit(paddr, QGI_IDX_GAIN);
    wire hit_ilv    = qgi_hit(paddr, QGI_IDX_ILV);
    wire hit_status = qgi_hit(paddr, QGI_IDX_STATUS);
    wire hit_any    = hit_gain || hit_ilv || hit_status;

    // Bus phases
    wire setup_ph   = psel && !penable;
    wire access_ph  = psel && penable;
    // Status is read-only; writing it is refused like an unmapped address
    wire bad_access = !hit_any || (hit_status && pwrite);
    wire wr_ok      = access_ph && pwrite && !bad_access;
    wire wr_gain    = wr_ok && hit_gain;
    wire wr_ilv     = wr_ok && hit_ilv;

    // Sampling clock edges
    wire half_end   = half_cnt_q == HW'(HALF_CYC - 1);
    wire rise_tick  = half_end && phase_q;                   // Entering the first half
    wire fall_tick  = half_end && !phase_q;                  // Entering the second half

    // Status word: derived state only, never the stored fields
    logic [QGI_DW-1:0] status_w;
    always_comb
    begin
        status_w = '0;
        status_w[QGI_ST_LOCK]  = phase_locked;
        // Advisory flags; the device still obeys whatever was written
        status_w[QGI_ST_BAND]  = gain_q < QGI_GAIN_LO || gain_q > QGI_GAIN_HI;
        status_w[QGI_ST_MANIL] = mode_q.interleave_enable
                                 && !mode_q.auto_phase_control;
    end

    // Read data: the write-only registers answer zero
    wire [QGI_DW-1:0] rdata_d = hit_status ? status_w : '0;

    // Gain register; only bits 15:7 are kept, the filler bits are dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gain_q <= QGI_GAIN_RST[QGI_GAIN_MSB:QGI_GAIN_LSB];
        else if (wr_gain)
            gain_q <= pwdata[QGI_GAIN_MSB:QGI_GAIN_LSB];
    end

    // Gain write pulse; deliberately no calibration request is raised
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            upd_q <= 1'b0;
        else
            upd_q <= wr_gain;
    end

    // Full scale follows the code on the next edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fsr_q <= FSR_RST_MV;
        else
            fsr_q <= fsr_mv(gain_q);
    end

    // Interleave register; bits 13:0 carry nothing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q.interleave_enable  <= QGI_ILV_RST[QGI_ILV_BIT];
            mode_q.auto_phase_control <= QGI_ILV_RST[QGI_ACP_BIT];
        end
        else if (wr_ilv)
        begin
            mode_q.interleave_enable  <= pwdata[QGI_ILV_BIT];
            mode_q.auto_phase_control <= pwdata[QGI_ACP_BIT];
        end
    end

    // Read data is captured in the setup cycle so access needs no wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_q <= '0;
        else if (setup_ph)
            rdata_q <= rdata_d;
    end

    // Sample clock divider: one half period is HALF_CYC bus cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            half_cnt_q <= '0;
            phase_q    <= 1'b0;
        end
        else if (half_end)
        begin
            half_cnt_q <= '0;
            phase_q    <= !phase_q;
        end
        else
            half_cnt_q <= half_cnt_q + HW'(1);
    end

    // Strobes: interleaved pair alternates edges, otherwise both on the rise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            smp_q <= '0;
        else if (mode_q.interleave_enable)
        begin
            smp_q.i_sample       <= rise_tick;
            smp_q.q_sample       <= fall_tick;
            smp_q.q_from_i_input <= 1'b1;
        end
        else
        begin
            smp_q.i_sample       <= rise_tick;
            smp_q.q_sample       <= rise_tick;
            smp_q.q_from_i_input <= 1'b0;
        end
    end

    // Loop update pacing; keeps the detector from hunting every cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            upd_cnt_q  <= '0;
            upd_tick_q <= 1'b0;
        end
        else if (upd_cnt_q == UW'(UPD_CYC - 1))
        begin
            upd_cnt_q  <= '0;
            upd_tick_q <= 1'b1;
        end
        else
        begin
            upd_cnt_q  <= upd_cnt_q + UW'(1);
            upd_tick_q <= 1'b0;
        end
    end

    // Inter-channel delay: loop or manual fields
    qgi_phase_align #(
        .CW              (CW),
        .FW              (FW)
    ) u_align (
        .pclk            (pclk),
        .presetn         (presetn),
        .update          (upd_tick_q),
        .auto_en         (mode_q.auto_phase_control),
        .manual_coarse   (manual_coarse),
        .manual_fine     (manual_fine),
        .phase_early_pin (phase_early_pin),
        .phase_late_pin  (phase_late_pin),
        .sample_delay    (sample_delay),
        .phase_locked    (phase_locked)
    );

    // APB answers in the first access cycle
    assign pready         = 1'b1;
    assign pslverr        = access_ph && bad_access;
    assign prdata         = rdata_q;

    // Block outputs
    assign q_gain_code    = gain_q;
    assign q_fullscale_mv = fsr_q;
    assign gain_update    = upd_q;
    assign mode           = mode_q;
    assign sample         = smp_q;

endmodule // qgi_ctrl

// File: verif/qgi_ctrl_chk.sv
`timescale 1ns/1ps
module qgi_ctrl_chk
    import qgi_pkg::*;
#(
    parameter int unsigned CW = 3,                // Coarse delay width
    parameter int unsigned FW = 9                 // Fine delay width
)(
    input wire logic              pclk,           // Bus clock
    input wire logic              presetn,        // Async reset, low
    input wire logic              psel,           // APB select
    input wire logic              penable,        // APB access phase
    input wire logic              pwrite,         // APB direction
    input wire logic [QGI_AW-1:0] paddr,          // APB address
    input wire logic [QGI_DW-1:0] pwdata,         // APB write data
    input wire logic [QGI_DW-1:0] prdata,         // APB read data
    input wire logic              pready,         // APB ready
    input wire logic [CW-1:0]     manual_coarse,  // Manual coarse delay
    input wire logic [FW-1:0]     manual_fine,    // Manual fine delay
    input wire logic [8:0]        q_gain_code,    // Gain code
    input wire logic [9:0]        q_fullscale_mv, // Full scale
    input wire logic              gain_update,    // Gain pulse
    input wire qgi_mode_t         mode,           // Mode bits
    input wire qgi_sample_t       sample,         // Strobes
    input wire logic [CW+FW-1:0]  sample_delay    // Delay
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed accesses to the two write-only words
    wire logic acc     = psel && penable && pready;
    wire logic hit_g   = paddr == 8'h2c;
    wire logic hit_i   = paddr == 8'h34;
    wire logic wr_gain = acc && pwrite && hit_g;
    wire logic wr_ilv  = acc && pwrite && hit_i;
    sequence s_gain_wr; wr_gain; endsequence
    sequence s_pulse; gain_update ##1 !gain_update; endsequence
    property p_gain_pulse; s_gain_wr |=> s_pulse; endproperty
    a_gain_pulse: assert property (p_gain_pulse) else $error("gain pulse wrong");
    property p_gain_load; s_gain_wr |=> q_gain_code == $past(pwdata[15:7]); endproperty
    a_gain_load: assert property (p_gain_load) else $error("gain code not stored");
    // Full scale follows the code one cycle later: 560 + code*281/512
    property p_fsr; q_fullscale_mv == 10'(10'h230 + ((19'($past(q_gain_code)) * 19'h119) >> 9)); endproperty
    a_fsr: assert property (p_fsr) else $error("full scale mismatch");
    property p_ilv_load; wr_ilv |=> mode == $past(pwdata[15:14]); endproperty
    a_ilv_load: assert property (p_ilv_load) else $error("mode not stored");
    property p_ilv_keep; !wr_ilv |=> $stable(mode); endproperty
    a_ilv_keep: assert property (p_ilv_keep) else $error("mode changed alone");
    property p_rd_wo; acc && !pwrite && (hit_g || hit_i) |-> prdata == 32'h0000_0000; endproperty
    a_rd_wo: assert property (p_rd_wo) else $error("write-only word readable");
    property p_manual; $past(!mode.auto_phase_control) |-> sample_delay == $past({manual_coarse, manual_fine});
    endproperty
    a_manual: assert property (p_manual) else $error("manual delay not applied");
    property p_alt; $past(mode.interleave_enable) && sample.i_sample |-> !sample.q_sample; endproperty
    a_alt: assert property (p_alt) else $error("interleaved strobes coincide");
    property p_sep; $past(!mode.interleave_enable) |-> sample.i_sample == sample.q_sample; endproperty
    a_sep: assert property (p_sep) else $error("independent strobes split");
endmodule // qgi_ctrl_chk

bind qgi_ctrl qgi_ctrl_chk #(.CW(CW), .FW(FW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .manual_coarse(manual_coarse), .manual_fine(manual_fine), .q_gain_code(q_gain_code),
    .q_fullscale_mv(q_fullscale_mv), .gain_update(gain_update), .mode(mode), .sample(sample),
    .sample_delay(sample_delay));

// File: verif/qgi_det_model.sv
`timescale 1ns/1ps
// Phase detector standing beside the converter pair; drives its verdict pins
module qgi_det_model (
    input  wire logic       pclk,      // Clock
    input  wire logic [1:0] cmd,       // 0 aligned, 1 second edge late, 2 early
    output logic            early_pin, // Second edge early
    output logic            late_pin   // Second edge late
);
    // Verdict changes only after an edge, as a real detector would settle
    always_ff @(posedge pclk)
    begin
        late_pin  <= cmd == 2'h1;
        early_pin <= cmd == 2'h2;
    end
endmodule // qgi_det_model

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import qgi_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, gain_update, phase_locked, early, late;
    logic [7:0]  paddr;         // Byte address
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  manual_coarse; // Manual coarse
    logic [8:0]  manual_fine, q_gain_code;
    logic [9:0]  q_fullscale_mv;
    logic [11:0] sample_delay, d0;
    logic [1:0]  det_cmd;       // Detector verdict request
    qgi_mode_t   mode;          // Mode bits
    qgi_sample_t sample;        // Strobes
    logic        err;
    int          errors, num_checks, cyc, n_i, n_q, n_both;
    logic [8:0]  codes [5] = '{9'h000, 9'h0c0, 9'h1c0, 9'h1ff, 9'h100};
    // Short loop update keeps the detector scenario brief
    qgi_ctrl #(.UPD_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .manual_coarse(manual_coarse), .manual_fine(manual_fine),
        .phase_early_pin(early), .phase_late_pin(late), .q_gain_code(q_gain_code),
        .q_fullscale_mv(q_fullscale_mv), .gain_update(gain_update), .mode(mode), .sample(sample),
        .sample_delay(sample_delay), .phase_locked(phase_locked));
    qgi_det_model u_det (.pclk(pclk), .cmd(det_cmd), .early_pin(early), .late_pin(late));
    initial
    begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end
    // Hang guard: far above the fewer than two hundred cycles the tests need
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            errors = errors + 1;
            complete_run();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
            errors = errors + 1;
        end
    endtask
    // One APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    function automatic logic [9:0] fsr(input logic [8:0] c);
        return 10'(10'h230 + ((19'(c) * 19'h119) >> 9));
    endfunction
    task automatic count_strobes();
        n_i = 0; n_q = 0; n_both = 0;
        repeat (8)
        begin
            @(posedge pclk); #1;
            n_i += sample.i_sample; n_q += sample.q_sample; n_both += sample.i_sample & sample.q_sample;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        errors = 0; num_checks = 0; cyc = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 8'h00; pwdata = 32'h0000_0000; manual_coarse = 3'h0; manual_fine = 9'h000; det_cmd = 2'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1;
        #1;
        check("gain reset", q_gain_code, 9'h100);
        check("fsr reset", q_fullscale_mv, 10'h2bc);
        check("mode reset", mode, 2'h0);
        $display("test reset done");
        // Gain codes across the range and at the advised band edges, filler ones below
        foreach (codes[k])
        begin
            apb(1, 8'h2c, {16'h0000, codes[k], 7'h7f});
            check("gain err", err, 0);
            repeat (2) @(posedge pclk); #1;
            check("gain code", q_gain_code, codes[k]);
            check("fsr", q_fullscale_mv, fsr(codes[k]));
            apb(0, 8'h2c, 32'h0000_0000);
            check("gain read", rd, 32'h0000_0000);
            apb(0, 8'h40, 32'h0000_0000);
            check("band flag", rd, {30'h0000_0000, (codes[k] < 9'h0c0 || codes[k] > 9'h1c0), 1'b0});
        end
        apb(1, 8'h2d, 32'h0000_007f);
        check("misaligned err", err, 1);
        apb(0, 8'h3c, 32'h0000_0000);
        check("unmapped err", err, 1);
        #1 check("gain kept", q_gain_code, 9'h100);
        $display("test gain done");
        apb(1, 8'h34, 32'h0000_3fff);
        count_strobes();
        check("indep i", n_i, 2);
        check("indep both", n_both, 2);
        check("indep src", sample.q_from_i_input, 0);
        apb(1, 8'h34, 32'h0000_ffff);
        count_strobes();
        check("ilv mode", mode, 2'h3);
        check("ilv i", n_i, 2);
        check("ilv q", n_q, 2);
        check("ilv both", n_both, 0);
        check("ilv src", sample.q_from_i_input, 1);
        apb(0, 8'h34, 32'h0000_0000);
        check("ilv read", rd, 32'h0000_0000);
        $display("test interleave done");
        apb(1, 8'h34, 32'h0000_bfff);
        manual_coarse <= 3'h5; manual_fine <= 9'h1a3;
        repeat (3) @(posedge pclk); #1;
        check("manual delay", sample_delay, 12'hba3);
        apb(0, 8'h40, 32'h0000_0000);
        check("status manual", rd, 32'h0000_0004);
        apb(1, 8'h34, 32'h0000_7fff);
        repeat (12) @(posedge pclk); #1;
        check("auto start", sample_delay, 12'h000);
        d0 = sample_delay;
        manual_coarse <= 3'h2; manual_fine <= 9'h055;
        repeat (12) @(posedge pclk); #1;
        check("manual ignored", sample_delay, 12'h000);
        check("locked", phase_locked, 1);
        apb(0, 8'h40, 32'h0000_0000);
        check("status lock", rd, 32'h0000_0001);
        apb(1, 8'h40, 32'h0000_ffff);
        check("status wr err", err, 1);
        det_cmd <= 2'h1;
        repeat (20) @(posedge pclk); #1;
        check("late steers", sample_delay > d0, 1);
        check("late unlocked", phase_locked, 0);
        d0 = sample_delay;
        det_cmd <= 2'h2;
        repeat (20) @(posedge pclk); #1;
        check("early steers", sample_delay < d0, 1);
        det_cmd <= 2'h0;
        $display("test phase done");
        complete_run();
    end
endmodule // tb_top
